// [sim/qcp_pin_model.sv]
// Far-side model of the second converter port pins
`default_nettype none
module qcp_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pin_o_i,
	input wire logic [W-1:0] oe_i,
	input wire logic [W-1:0] ext_i,
	output logic [W-1:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Pin level
	// Device drive wins where enabled; the outside source holds the rest
	assign pin_i = (oe_i & pin_o_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the converter control slice
`include "qcp_defs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import qcp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_i = 1'b0;
	logic queue_busy_i = 1'b0;
	qcp_req_type req_data_i = '0;
	logic ready_o, ack_o, qclk_tick_o, qclk_o;
	logic [15:0] rdata_o, rd;
	logic [7:0] pin_i, pin_o, pin_oe_o;
	logic [7:0] ext = 8'h5a;
	int num_errors = 0;
	int checks = 0;
	int seed = 32'hd34400b7;
	int regs [4] = '{0, 0, 0, 0};
	int d, n, h;
	always #2 clk_i = ~clk_i;
	qcp_ctrl #(.PORT_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
		.req_data_i(req_data_i), .ready_o(ready_o), .ack_o(ack_o), .rdata_o(rdata_o),
		.queue_busy_i(queue_busy_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.qclk_tick_o(qclk_tick_o), .qclk_o(qclk_o));
	qcp_pin_model #(.W(8)) pins (.pin_o_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .pin_i(pin_i));
	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Access port; request held until the take edge
	task automatic op(input logic we, input logic [1:0] a, input logic [15:0] v);
		logic bz;
		logic [15:0] e;
		int k;
		bz = 1'($random(seed));
		k = 0;
		e = regs[a][15:0];
		if (a == `QCP_IDX_PIN) e = {8'h00, (regs[1][7:0] & regs[2][7:0]) | (~regs[1][7:0] & ext)};
		req_i <= 1'b1;
		req_data_i <= {we, a, v};
		queue_busy_i <= bz;
		do @(posedge clk_i); while (ready_o !== 1'b1);
		req_i <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
			if (k == 1) chk(ready_o, 1'b0);
		end while (ack_o !== 1'b1 && k < 20);
		chk(k, bz ? 4 : 3);
		chk(ready_o, 1'b1);
		if (!we) chk(rdata_o, e);
		if (we && a != `QCP_IDX_PIN) regs[a] = v & (a == `QCP_IDX_CTRL0 ? 16'h007f : 16'h00ff);
	endtask
	// Cycles to the next prescaler tick, bounded, and converter clock high cycles
	task automatic tick_gap(output int c, output int h);
		c = 0;
		h = 0;
		do begin
			@(posedge clk_i);
			c++;
			if (qclk_o === 1'b1) h++;
		end while (qclk_tick_o !== 1'b1 && c < 300);
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(pin_oe_o, 8'h00);
		for (int a = 0; a < 4; a++) op(1'b0, a[1:0], 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			ext <= 8'($random(seed));
			op(1'b1, `QCP_IDX_DDR, 16'($random(seed)));
			chk(pin_oe_o, regs[1][7:0]);
			op(1'b1, `QCP_IDX_DATA, 16'($random(seed)));
			chk(pin_o, regs[2][7:0]);
			op(1'b1, `QCP_IDX_PIN, 16'hffff);
			op(1'b0, `QCP_IDX_PIN, 16'h0000);
			op(1'b0, `QCP_IDX_DDR, 16'h0000);
		end
		$display("test port done");
		for (int i = 0; i < 6; i++) begin
			d = (i < 4) ? (i == 3 ? 127 : i) : ($random(seed) & 127);
			op(1'b1, `QCP_IDX_CTRL0, 16'(d));
			op(1'b0, `QCP_IDX_CTRL0, 16'h0000);
			tick_gap(n, h);
			tick_gap(n, h);
			chk(n, (d == 0 ? 1 : d) + 1);
			chk(h, ((d == 0 ? 1 : d) + 2) / 2);
		end
		$display("test prescaler done");
		report_and_stop();
	end
	// Hang guard, well beyond the thousand or so cycles the tests need
	initial begin
		#80000;
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// [src/qcp_ctrl.sv]
// Converter control slice: prescaler, second port direction, register access
// Function
// - Each second-port pin selectable input or output
// - All second-port pins are inputs after reset
// - Converter clock is system clock over field+1
// - Divider field zero behaves as one
// - Register access completes in three or four cycles
`include "qcp_defs.svh"
`default_nettype none
module qcp_ctrl #(
	parameter int PORT_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire qcp_pkg::qcp_req_type req_data_i,
	output logic ready_o,
	output logic ack_o,
	output logic [15:0] rdata_o,
	input wire logic queue_busy_i,
	input wire logic [PORT_W-1:0] pin_i,
	output logic [PORT_W-1:0] pin_o,
	output logic [PORT_W-1:0] pin_oe_o,
	output logic qclk_tick_o,
	output logic qclk_o
);
	import qcp_pkg::*;

	qcp_state_type state_q;
	qcp_req_type req_q;
	logic [2:0] cnt_q;
	logic ack_q;
	logic [15:0] rdata_q;
	logic [15:0] rd_val;
	logic take;
	logic [`QCP_DIV_W-1:0] div_q;
	logic [PORT_W-1:0] ddr_q;
	logic [PORT_W-1:0] out_q;
	logic [PORT_W-1:0] sync1_q;
	logic [PORT_W-1:0] sync2_q;

	// ==========================================================
	// Access sequencing
	assign ready_o = (state_q == QCP_IDLE);
	assign take = ready_o && req_i;

	// Latency is fixed when the access is taken, so a queue that goes
	// busy midway cannot stretch an access already under way
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= QCP_IDLE;
			cnt_q <= 3'h0;
		end else begin
			unique case (state_q)
				QCP_IDLE: begin
					if (take) begin
						state_q <= QCP_WAIT;
						cnt_q <= (queue_busy_i ? `QCP_LAT_BUSY : `QCP_LAT_IDLE) - 3'h1;
					end
				end
				QCP_WAIT: begin
					if (cnt_q == 3'h1) begin
						state_q <= QCP_IDLE;
					end
					cnt_q <= cnt_q - 3'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_q <= '0;
		end else if (take) begin
			req_q <= req_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (state_q == QCP_WAIT) && (cnt_q == 3'h1);
		end
	end
	assign ack_o = ack_q;

	// ==========================================================
	// Registers written at completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= `QCP_DIV_RST;
		end else if (state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we
			&& req_q.addr == `QCP_IDX_CTRL0) begin
			div_q <= req_q.wdata[`QCP_DIV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ddr_q <= PORT_W'(`QCP_DDR_RST);
		end else if (state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we
			&& req_q.addr == `QCP_IDX_DDR) begin
			ddr_q <= req_q.wdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= PORT_W'(`QCP_DATA_RST);
		end else if (state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we
			&& req_q.addr == `QCP_IDX_DATA) begin
			out_q <= req_q.wdata[PORT_W-1:0];
		end
	end

	// ==========================================================
	// Read path
	always_comb begin
		rd_val = 16'h0000;
		unique case (req_q.addr)
			`QCP_IDX_CTRL0: rd_val[`QCP_DIV_W-1:0] = div_q;
			`QCP_IDX_DDR: rd_val[PORT_W-1:0] = ddr_q;
			`QCP_IDX_DATA: rd_val[PORT_W-1:0] = out_q;
			`QCP_IDX_PIN: rd_val[PORT_W-1:0] = sync2_q;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
		end else if (state_q == QCP_WAIT && cnt_q == 3'h1 && !req_q.we) begin
			rdata_q <= rd_val;
		end
	end
	assign rdata_o = rdata_q;

	// ==========================================================
	// Second converter port pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	// A set direction bit drives the pin of the same index
	assign pin_oe_o = ddr_q;
	assign pin_o = out_q;

	// ==========================================================
	// Prescaler
	qcp_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_i(div_q),
		.tick_o(qclk_tick_o),
		.qclk_o(qclk_o)
	);

	// ==========================================================
	// Checks
	a_lat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && !queue_busy_i) |=> !ack_o ##1 !ack_o ##1 ack_o)
		else $error("idle access not done in three cycles");
	a_lat_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && queue_busy_i) |=> !ack_o ##1 !ack_o ##1 !ack_o ##1 ack_o)
		else $error("busy access not done in four cycles");
	a_reset_inputs: assert property (@(posedge clk_i)
		$past(rst_i) |-> (pin_oe_o == '0))
		else $error("port pin driven after reset");
	a_ddr_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_DDR)
		|=> (pin_oe_o == $past(req_q.wdata[PORT_W-1:0])) && ack_o)
		else $error("direction write not applied to pins");
	a_ddr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_DDR)
		|=> $stable(pin_oe_o))
		else $error("pin direction changed without a write");
	a_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_CTRL0)
		|=> div_q == $past(req_q.wdata[`QCP_DIV_W-1:0]))
		else $error("divider field not updated");
	a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_CTRL0)
		|=> $stable(div_q))
		else $error("divider field changed without a write");
	a_div_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == QCP_WAIT && cnt_q == 3'h1 && !req_q.we && req_q.addr == `QCP_IDX_CTRL0)
		|=> rdata_o == 16'($past(div_q)))
		else $error("divider field read back wrong");
	a_qclk_reset: assert property (@(posedge clk_i)
		$past(rst_i) |-> !qclk_o)
		else $error("converter clock high out of reset");

	// ==========================================================
	// Port and access checks
	// Values must not drift between accesses, since software polls them
	a_data_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_DATA)
		|=> pin_o == $past(req_q.wdata[PORT_W-1:0]))
		else $error("output data write not applied to pins");
	a_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(state_q == QCP_WAIT && cnt_q == 3'h1 && req_q.we && req_q.addr == `QCP_IDX_DATA)
		|=> $stable(pin_o))
		else $error("pin output changed without a write");
	a_pin_sync: assert property (@(posedge clk_i) disable iff (rst_i)
		(!$past(rst_i) && !$past(rst_i, 2)) |-> sync2_q == $past(pin_i, 2))
		else $error("pin readback not two cycles behind the pins");
	a_ready_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> !ready_o ##1 !ready_o)
		else $error("port ready during an access");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("completion pulse longer than one cycle");
	a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(state_q == QCP_WAIT && cnt_q == 3'h1 && !req_q.we)
		|=> $stable(rdata_o))
		else $error("read data changed without a read");
endmodule
`default_nettype wire

// [src/qcp_defs.svh]
// Constants for the converter prescaler and port-direction control slice
`ifndef QCP_DEFS_SVH
`define QCP_DEFS_SVH

// ==========================================================
// Register indices on the access port
`define QCP_IDX_CTRL0 2'h0
`define QCP_IDX_DDR 2'h1
`define QCP_IDX_DATA 2'h2
`define QCP_IDX_PIN 2'h3

// ==========================================================
// Field layout and reset values
`define QCP_DIV_W 7
`define QCP_DIV_RST 7'h00
`define QCP_DIV_MIN 7'h01
`define QCP_DDR_RST 16'h0000
`define QCP_DATA_RST 16'h0000

// ==========================================================
// Access latency in system clock cycles
`define QCP_LAT_IDLE 3'h3
`define QCP_LAT_BUSY 3'h4

`endif

// [src/qcp_pkg.sv]
// Types for the converter prescaler and port-direction control slice
`default_nettype none
package qcp_pkg;
	typedef struct packed {
		logic we;
		logic [1:0] addr;
		logic [15:0] wdata;
	} qcp_req_type;

	typedef enum logic {
		QCP_IDLE,
		QCP_WAIT
	} qcp_state_type;
endpackage
`default_nettype wire

// [src/qcp_prescaler.sv]
// Converter clock prescaler: divides the system clock by field plus one
`include "qcp_defs.svh"
`default_nettype none
module qcp_prescaler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`QCP_DIV_W-1:0] div_i,
	output logic tick_o,
	output logic qclk_o
);
	import qcp_pkg::*;

	logic [`QCP_DIV_W-1:0] top;
	logic [`QCP_DIV_W-1:0] cnt_q;
	logic [`QCP_DIV_W-1:0] cnt_d;
	logic qclk_q;
	logic [7:0] gap_q;
	logic [`QCP_DIV_W-1:0] div_prev_q;

	// ==========================================================
	// Divider
	// Zero is read as one, so the undivided clock never appears
	assign top = (div_i == '0) ? `QCP_DIV_MIN : div_i;
	// Counting 0..top gives top+1 system cycles per period
	assign cnt_d = (cnt_q >= top) ? '0 : cnt_q + `QCP_DIV_W'(1);
	assign tick_o = (cnt_q >= top);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// High for the first top/2+1 cycles of each period, low for the rest
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qclk_q <= 1'b0;
		end else begin
			qclk_q <= (cnt_d <= (top >> 1));
		end
	end
	assign qclk_o = qclk_q;

	// ==========================================================
	// Checks
	always_ff @(posedge clk_i) begin
		if (rst_i || tick_o) begin
			gap_q <= 8'h01;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		div_prev_q <= div_i;
	end

	a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_o && $stable(div_i) && div_i != '0 && $past(tick_o, 1) == 1'b0
			&& gap_q < 8'hff && div_prev_q == div_i && $past(rst_i) == 1'b0)
		|-> (gap_q == {1'b0, div_i} + 8'h01))
		else $error("prescaler period differs from divider plus one");
	a_zero_as_one: assert property (@(posedge clk_i) disable iff (rst_i)
		(div_i == '0 && $past(div_i) == '0 && tick_o) |=> !tick_o)
		else $error("zero divider produced undivided clock");
	a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_o && div_i == 7'h02) ##1 (div_i == 7'h02)[*3]
		|-> tick_o && !$past(tick_o) && !$past(tick_o, 2))
		else $error("divide by three period wrong");
endmodule
`default_nettype wire
